// ### design/fvs_launch_check.sv
// launch check: command code and parameter validation
`timescale 1ns/1ps
module fvs_launch_check
  import fvs_pkg::*;
(
  input  wire logic [7:0]  cmd,
  input  wire logic [2:0]  word_index,
  input  wire logic [15:0] word0,
  input  wire logic [15:0] word1,
  input  wire logic [15:0] word2,
  input  wire logic        clk_div_set,
  input  wire logic        special_mode,
  output logic             known_cmd,
  output logic             access_error,
  output logic             mass_class
);
  wire logic [1:0]  blk        = word0[1:0];
  wire logic        blk_ok     = (blk == BLK_DATA) || (blk == BLK_PROG_LO) || (blk == BLK_PROG_HI);
  wire logic        prog_blk   = (blk == BLK_PROG_LO) || (blk == BLK_PROG_HI);
  wire logic [17:0] sec_start  = {blk, word1};
  wire logic [17:0] sec_len    = {word2[14:0], 3'h0};
  wire logic [18:0] sec_end    = {1'b0, sec_start} + {1'b0, sec_len};
  // limit in 19 bits: the top page of block 3 ends at 2**18
  wire logic        crosses    = (sec_end > ({1'b0, sec_start & ~(BOUNDARY_BYTES - 18'h1)} + {1'b0, BOUNDARY_BYTES}))
                                 || (word2[15] == 1'b1);
  wire logic        writes_mem = (cmd == CMD_PROGRAM) || (cmd == CMD_PROGRAM_ONCE) || (cmd == CMD_ERASE_ALL)
                                 || (cmd == CMD_ERASE_BLOCK) || (cmd == CMD_ERASE_SECTOR)
                                 || (cmd == CMD_UNSECURE) || (cmd == CMD_DATA_PROGRAM)
                                 || (cmd == CMD_DATA_SECTOR);

  assign known_cmd  = writes_mem || (cmd inside {CMD_VERIFY_ALL, CMD_VERIFY_BLOCK, CMD_VERIFY_SECTION,
                                   CMD_READ_ONCE, CMD_VERIFY_KEY, CMD_USER_MARGIN, CMD_FIELD_MARGIN,
                                   CMD_DATA_SECTION});
  assign mass_class = (cmd == CMD_ERASE_ALL) || (cmd == CMD_ERASE_BLOCK);

  always_comb begin
    access_error = 1'b0;
    if (!known_cmd) begin
      access_error = 1'b1;
    end else if (writes_mem && !clk_div_set) begin
      access_error = 1'b1;
    end else begin
      unique case (cmd)
        CMD_VERIFY_ALL:     access_error = (word_index != IDX_0);
        CMD_VERIFY_BLOCK:   access_error = (word_index != IDX_0) || !blk_ok;
        CMD_VERIFY_SECTION: access_error = (word_index != IDX_2) || !prog_blk
                                           || (word1[2:0] != PHRASE_ALIGN) || crosses || !special_mode;
        CMD_READ_ONCE:      access_error = (word_index != IDX_1) || (word1 > ONCE_MAX_IDX)
                                           || !special_mode;
        CMD_FIELD_MARGIN:   access_error = !special_mode;
        default:            access_error = 1'b0;
      endcase
    end
  end
endmodule

// ### design/fvs_sequencer.sv
// flash verify/read sequencer top
//
// Function
// - program-array reads allowed while data array margin reads, programs or sector-erases.
// - only margin/margin, sector/sector, mass/mass pairs allowed concurrently; others refused.
// - after non-normal margin level selected, every array read counts as margin read.
// - erase-all and erase-block both class as mass erase.
// - program/erase before clock divider set raises access error, command dropped.
// - invalid command code raises access error, command dropped.
// - read of an array busy with an algorithm returns invalid data.
// - such invalid read sets both fault flags when neither was set.
// - code 01 with index 000 verifies both arrays erased, then completes.
// - verify-all and verify-block raise access error unless index is 000.
// - verify reads set error flag 1 on any error, flag 0 on uncorrectable.
// - code 02 verifies block from address bits 17:16; bad block is access error.
// - code 03 verifies section from block, first phrase and phrase count words.
// - section verify errors: index not 010, bad address, misaligned, crosses 128 kbyte.
// - section verify and read-once raise access error in unavailable modes.
// - code 04 fetches one-time phrase 0..7 into words 010..101, then completes.
// - read-once raises access error if index not 001 or phrase out of range.
// - during read-once, program array reads return invalid data.
`timescale 1ns/1ps
module fvs_sequencer
  import fvs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        param_wr,
  input  wire logic [2:0]  param_wr_index,
  input  wire logic [15:0] param_wr_data,
  input  wire logic [2:0]  parameter_word_index,
  output logic [15:0]      command_parameter_words [NUM_WORDS],
  input  wire logic        launch,
  input  wire logic        flash_clock_divider_set,
  input  wire logic        special_mode,
  input  wire logic        clear_access_error,
  input  wire logic        clear_protection_violation,
  input  wire logic        clear_fault_flags,
  input  wire logic [4:0]  data_op,
  input  wire logic        data_busy,
  input  wire logic        prog_op_req,
  input  wire logic [7:0]  prog_op_cmd,
  output logic             prog_op_grant,
  input  wire logic        prog_read,
  input  wire logic        data_read,
  output logic             prog_read_invalid,
  output logic             data_read_invalid,
  output logic             margin_read,
  input  wire logic        verify_error,
  input  wire logic        verify_uncorrectable,
  input  wire logic [15:0] once_field [ONCE_WORDS],
  output logic             command_complete_flag,
  output logic             access_error_flag,
  output logic             protection_violation_flag,
  output logic             verify_error_flag_1,
  output logic             verify_error_flag_0,
  output logic             single_fault_detect_flag,
  output logic             double_fault_detect_flag,
  output logic [2:0]       verify_target
);
  fvs_state_t  state;
  fvs_state_t  next_state;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [1:0]  margin_level;
  logic        clk_div_sync1;
  logic        clk_div_sync2;
  logic        mode_sync1;
  logic        mode_sync2;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clk_div_sync1 <= 1'b0;
      clk_div_sync2 <= 1'b0;
      mode_sync1    <= 1'b0;
      mode_sync2    <= 1'b0;
    end else begin
      clk_div_sync1 <= flash_clock_divider_set;
      clk_div_sync2 <= clk_div_sync1;
      mode_sync1    <= special_mode;
      mode_sync2    <= mode_sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // launch decode
  wire logic [7:0] cmd_code = command_parameter_words[0][15:8];
  wire logic       known_cmd;
  wire logic       launch_err;
  wire logic       cmd_mass;
  wire logic       busy      = (state != FVS_ST_IDLE);
  // software leaves errors cleared before launching; a stale one blocks launch
  wire logic       err_held  = access_error_flag || protection_violation_flag;
  wire logic       take      = launch && !busy && !err_held;
  wire logic       start_ok  = take && !launch_err;

  fvs_launch_check u_check (
    .cmd          (cmd_code),
    .word_index   (parameter_word_index),
    .word0        (command_parameter_words[0]),
    .word1        (command_parameter_words[1]),
    .word2        (command_parameter_words[2]),
    .clk_div_set  (clk_div_sync2),
    .special_mode (mode_sync2),
    .known_cmd    (known_cmd),
    .access_error (launch_err),
    .mass_class   (cmd_mass)
  );

  wire logic is_verify  = cmd_code inside {CMD_VERIFY_ALL, CMD_VERIFY_BLOCK, CMD_VERIFY_SECTION};
  wire logic is_once    = (cmd_code == CMD_READ_ONCE);
  wire logic is_margin  = (cmd_code == CMD_USER_MARGIN) || (cmd_code == CMD_FIELD_MARGIN);
  wire logic [1:0] blk  = command_parameter_words[0][1:0];

  // length of the verify walk in phrases
  function automatic logic [15:0] verify_len(input logic [7:0] c, input logic [1:0] b, input logic [15:0] n);
    unique case (c)
      CMD_VERIFY_ALL:   verify_len = PROG_PHRASES + DATA_PHRASES;
      CMD_VERIFY_BLOCK: verify_len = (b == BLK_DATA) ? DATA_PHRASES : PROG_PHRASES;
      default:          verify_len = (n == 16'h0000) ? 16'h0001 : n;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command state machine
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      FVS_ST_IDLE: begin
        if (start_ok && is_verify) begin
          next_state = FVS_ST_VERIFY;
          next_count = verify_len(cmd_code, blk, command_parameter_words[2]);
        end else if (start_ok && is_once) begin
          next_state = FVS_ST_ONCE;
          next_count = ONCE_CYCLES;
        end
      end
      FVS_ST_VERIFY, FVS_ST_ONCE: begin
        next_count = count - 16'h0001;
        if (count == 16'h0001) begin
          next_state = FVS_ST_IDLE;
        end
      end
      default: begin
        next_state = FVS_ST_IDLE;
        next_count = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= FVS_ST_IDLE;
      count <= 16'h0000;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign command_complete_flag = !busy;
  assign verify_target         = (cmd_code == CMD_VERIFY_ALL) ? 3'b111 : {1'b0, blk};

  ////////////////////////////////////////////////////////////////////////////
  // parameter words
  wire logic [2:0] once_base = command_parameter_words[1][2:0];
  wire logic       once_load = (state == FVS_ST_ONCE) && (count == 16'h0001);

  genvar g;
  generate
    for (g = 0; g < NUM_WORDS; g++) begin : g_word
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          command_parameter_words[g] <= 16'h0000;
        end else if (once_load && g >= 2) begin
          command_parameter_words[g] <= once_field[{once_base, 2'(g - 2)}];
        end else if (param_wr && !busy && param_wr_index == 3'(g)) begin
          command_parameter_words[g] <= param_wr_data;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // margin level and read classification
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      margin_level <= MARGIN_NORMAL;
    end else if (start_ok && is_margin) begin
      margin_level <= command_parameter_words[1][1:0];
    end
  end

  wire logic any_read = prog_read || data_read;
  assign margin_read  = any_read && (margin_level != MARGIN_NORMAL);

  // program-array side may run alongside the data array only in table pairs
  wire logic prog_margin = (prog_op_cmd == 8'h00) && (margin_level != MARGIN_NORMAL);
  wire logic prog_sector = (prog_op_cmd == CMD_ERASE_SECTOR);
  wire logic prog_mass   = (prog_op_cmd == CMD_ERASE_ALL) || (prog_op_cmd == CMD_ERASE_BLOCK);
  // plain program-array reads stay valid under data margin/program/sector erase
  wire logic data_allows_read = (data_op == FVS_OP_MARGIN) || (data_op == FVS_OP_PROG)
                                || (data_op == FVS_OP_SECTOR) || (data_op == FVS_OP_IDLE);
  wire logic prog_plain  = (prog_op_cmd == 8'h00) && (margin_level == MARGIN_NORMAL);
  assign prog_op_grant = prog_op_req && (!data_busy || data_op == FVS_OP_IDLE
                         || (prog_plain && data_allows_read)
                         || (prog_margin && data_op == FVS_OP_MARGIN)
                         || (prog_sector && data_op == FVS_OP_SECTOR)
                         || (prog_mass && data_op == FVS_OP_MASS));
  wire logic verify_hits_prog = (state == FVS_ST_VERIFY) && ((cmd_code != CMD_VERIFY_BLOCK) || blk != BLK_DATA);
  wire logic verify_hits_data = (state == FVS_ST_VERIFY) && ((cmd_code == CMD_VERIFY_ALL)
                                || (cmd_code == CMD_VERIFY_BLOCK && blk == BLK_DATA));
  wire logic prog_bad = prog_read && (verify_hits_prog || state == FVS_ST_ONCE
                        || (data_busy && !data_allows_read));
  wire logic data_bad = data_read && (verify_hits_data || (data_busy && data_op != FVS_OP_IDLE));
  assign prog_read_invalid = prog_bad;
  assign data_read_invalid = data_bad;

  ////////////////////////////////////////////////////////////////////////////
  // status flags: hardware set wins over software clear
  wire logic set_access = take && launch_err;
  wire logic invalid_rd = prog_bad || data_bad;
  wire logic fault_set  = invalid_rd && !single_fault_detect_flag && !double_fault_detect_flag;
  wire logic in_verify  = (state == FVS_ST_VERIFY) || (state == FVS_ST_ONCE);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_error_flag_1       <= 1'b0;
      verify_error_flag_0       <= 1'b0;
      single_fault_detect_flag  <= 1'b0;
      double_fault_detect_flag  <= 1'b0;
    end else begin
      access_error_flag         <= set_access || (access_error_flag && !clear_access_error);
      // no command in this block raises a protection violation
      protection_violation_flag <= protection_violation_flag && !clear_protection_violation;
      if (start_ok && is_verify) begin
        verify_error_flag_1 <= 1'b0;
        verify_error_flag_0 <= 1'b0;
      end else if (in_verify) begin
        verify_error_flag_1 <= verify_error_flag_1 || verify_error;
        verify_error_flag_0 <= verify_error_flag_0 || verify_uncorrectable;
      end
      single_fault_detect_flag  <= fault_set || (single_fault_detect_flag && !clear_fault_flags);
      double_fault_detect_flag  <= fault_set || (double_fault_detect_flag && !clear_fault_flags);
    end
  end
endmodule

// ### dv/fvs_sequencer_props.sv
// checker: port-level properties of the flash verify/read sequencer
`timescale 1ns/1ps
module fvs_sequencer_props
  import fvs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        param_wr,
  input wire logic        launch,
  input wire logic [2:0]  parameter_word_index,
  input wire logic [15:0] command_parameter_words [NUM_WORDS],
  input wire logic [4:0]  data_op,
  input wire logic        data_busy,
  input wire logic        prog_op_req,
  input wire logic [7:0]  prog_op_cmd,
  input wire logic        prog_op_grant,
  input wire logic        prog_read,
  input wire logic        data_read,
  input wire logic        prog_read_invalid,
  input wire logic        data_read_invalid,
  input wire logic        command_complete_flag,
  input wire logic        access_error_flag,
  input wire logic        protection_violation_flag,
  input wire logic        single_fault_detect_flag,
  input wire logic        double_fault_detect_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // a launch the sequencer must take: idle and no pending error
  wire       go;
  wire [7:0] cmd;
  assign go  = launch && command_complete_flag && !access_error_flag && !protection_violation_flag;
  assign cmd = command_parameter_words[0][15:8];

  ////////////////////////////////////////////////////////////
  property p_bad_index;
    go && (cmd == CMD_VERIFY_ALL || cmd == CMD_VERIFY_BLOCK) && parameter_word_index != IDX_0
      |=> access_error_flag && command_complete_flag;
  endproperty
  a_bad_index: assert property (p_bad_index) else $error("verify launch with wrong index not refused");
  property p_bad_code;
    go && cmd == 8'h05 |=> access_error_flag && command_complete_flag;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("unknown command not refused");
  property p_verify_runs;
    go && cmd == CMD_VERIFY_ALL && parameter_word_index == IDX_0 |=> !command_complete_flag [*8];
  endproperty
  a_verify_runs: assert property (p_verify_runs) else $error("verify all did not hold complete low");
  property p_busy_hold;
    !command_complete_flag && param_wr |=> $stable(command_parameter_words[0]);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("parameter word changed while busy");
  property p_fault_both;
    (prog_read_invalid || data_read_invalid) && !single_fault_detect_flag && !double_fault_detect_flag
      |=> single_fault_detect_flag && double_fault_detect_flag;
  endproperty
  a_fault_both: assert property (p_fault_both) else $error("fault flags not both set");
  property p_rww;
    prog_read && command_complete_flag |-> !prog_read_invalid;
  endproperty
  a_rww: assert property (p_rww) else $error("program array read invalid while idle");
  property p_busy_read;
    data_read && data_busy |-> data_read_invalid;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy data array read not invalid");
  property p_pair;
    prog_op_req && data_busy && prog_op_cmd == CMD_PROGRAM |-> !prog_op_grant;
  endproperty
  a_pair: assert property (p_pair) else $error("program granted beside a data operation");
  property p_mass;
    prog_op_req && data_busy && command_complete_flag && data_op == FVS_OP_MASS
      && (prog_op_cmd == CMD_ERASE_ALL || prog_op_cmd == CMD_ERASE_BLOCK) |-> prog_op_grant;
  endproperty
  a_mass: assert property (p_mass) else $error("mass erase pair refused");

  c_verify: cover property (go && cmd == CMD_VERIFY_ALL);
  c_once: cover property (go && cmd == CMD_READ_ONCE);
  c_fault: cover property ($rose(single_fault_detect_flag));
endmodule

// ### dv/fvs_sequencer_tb_top.sv
// testbench: directed command sequences for the flash verify/read sequencer
`timescale 1ns/1ps
module fvs_sequencer_tb_top;
  import fvs_pkg::*;
  logic        ref_clk, sys_rst, param_wr, launch, flash_clock_divider_set, special_mode;
  logic        clear_access_error, clear_protection_violation, clear_fault_flags, data_busy;
  logic        prog_op_req, prog_read, data_read, verify_error, verify_uncorrectable;
  logic [2:0]  param_wr_index, parameter_word_index, verify_target;
  logic [15:0] param_wr_data;
  logic [4:0]  data_op;
  logic [7:0]  prog_op_cmd;
  logic [15:0] command_parameter_words [NUM_WORDS];
  logic [15:0] once_field [ONCE_WORDS];
  logic        prog_op_grant, prog_read_invalid, data_read_invalid, margin_read, command_complete_flag;
  logic        access_error_flag, protection_violation_flag, verify_error_flag_1, verify_error_flag_0;
  logic        single_fault_detect_flag, double_fault_detect_flag;
  int          err_count, num_checks, n;

  fvs_sequencer uut (.ref_clk, .sys_rst, .param_wr, .param_wr_index, .param_wr_data, .parameter_word_index,
    .command_parameter_words, .launch, .flash_clock_divider_set, .special_mode, .clear_access_error,
    .clear_protection_violation, .clear_fault_flags, .data_op, .data_busy, .prog_op_req, .prog_op_cmd,
    .prog_op_grant, .prog_read, .data_read, .prog_read_invalid, .data_read_invalid, .margin_read,
    .verify_error, .verify_uncorrectable, .once_field, .command_complete_flag, .access_error_flag,
    .protection_violation_flag, .verify_error_flag_1, .verify_error_flag_0, .single_fault_detect_flag,
    .double_fault_detect_flag, .verify_target);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // leaves the strobe high so back-to-back writes never toggle it twice in one step
  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    param_wr_index = i;
    param_wr_data = d;
    param_wr = 1'b1;
    @(negedge ref_clk);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [1:0] b, input logic [15:0] w1, w2, input logic [2:0] x);
    wr(IDX_0, {c, 6'h00, b});
    wr(IDX_1, w1);
    wr(IDX_2, w2);
    param_wr = 1'b0;
    parameter_word_index = x;
    launch = 1'b1;
    @(negedge ref_clk);
    launch = 1'b0;
  endtask
  task automatic bad(input logic [7:0] c, input logic [1:0] b, input logic [15:0] w1, w2, input logic [2:0] x);
    cmd(c, b, w1, w2, x);
    chk("access error", 16'h0001, {15'h0000, access_error_flag});
    chk("complete", 16'h0001, {15'h0000, command_complete_flag});
    clear_access_error = 1'b1;
    @(negedge ref_clk);
    clear_access_error = 1'b0;
  endtask
  // counts busy cycles seen at falling edges; a hang ends the run
  task automatic wait_done(input int lim);
    n = 0;
    while (command_complete_flag !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= lim) begin
      err_count++;
      $display("unexpected timeout: expected complete within %0d seen busy", lim);
      stop_test();
    end
  endtask
  task automatic cc(input logic [4:0] op, input logic [7:0] c, input logic g);
    data_op = op;
    prog_op_cmd = c;
    prog_op_req = 1'b1;
    #1 chk("grant", {15'h0000, g}, {15'h0000, prog_op_grant});
    @(negedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, special_mode} = 2'b11;
    {param_wr, launch, flash_clock_divider_set, clear_access_error, clear_protection_violation} = 5'h00;
    {clear_fault_flags, data_busy, prog_op_req, prog_read, data_read, verify_error, verify_uncorrectable} = 7'h00;
    {param_wr_index, parameter_word_index, param_wr_data, prog_op_cmd} = 30'h0000_0000;
    data_op = FVS_OP_IDLE;
    for (int i = 0; i < ONCE_WORDS; i++) once_field[i] = 16'hA500 + 16'(i);
    err_count = 0;
    num_checks = 0;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("reset flags", 16'h0001, {access_error_flag, protection_violation_flag, verify_error_flag_1,
      verify_error_flag_0, single_fault_detect_flag, double_fault_detect_flag, command_complete_flag});
    chk("reset word0", 16'h0000, command_parameter_words[0]);
    bad(CMD_PROGRAM, BLK_PROG_LO, 16'h0000, 16'h0000, 3'h5);
    bad(8'h05, 2'h0, 16'h0000, 16'h0000, IDX_0);
    bad(CMD_VERIFY_ALL, 2'h0, 16'h0000, 16'h0000, IDX_1);
    bad(CMD_VERIFY_BLOCK, BLK_DATA, 16'h0000, 16'h0000, IDX_1);
    bad(CMD_VERIFY_BLOCK, 2'h1, 16'h0000, 16'h0000, IDX_0);
    bad(CMD_VERIFY_SECTION, BLK_PROG_HI, 16'hFFF0, 16'h0002, IDX_0);
    bad(CMD_VERIFY_SECTION, BLK_PROG_HI, 16'hFFF4, 16'h0001, IDX_2);
    bad(CMD_VERIFY_SECTION, BLK_PROG_HI, 16'hFFF8, 16'h0002, IDX_2);
    bad(CMD_VERIFY_SECTION, 2'h1, 16'h0000, 16'h0001, IDX_2);
    bad(CMD_READ_ONCE, 2'h0, 16'h0007, 16'h0000, IDX_0);
    bad(CMD_READ_ONCE, 2'h0, 16'h0008, 16'h0000, IDX_1);
    special_mode = 1'b0;
    repeat (3) @(negedge ref_clk);
    bad(CMD_VERIFY_SECTION, BLK_PROG_HI, 16'hFFF0, 16'h0002, IDX_2);
    bad(CMD_READ_ONCE, 2'h0, 16'h0007, 16'h0000, IDX_1);
    {special_mode, flash_clock_divider_set} = 2'b11;
    repeat (3) @(negedge ref_clk);
    $display("test launch errors done");
    cmd(CMD_VERIFY_ALL, 2'h0, 16'h0000, 16'h0000, IDX_0);
    chk("complete", 16'h0000, {15'h0000, command_complete_flag});
    chk("verify target", 16'h0007, {13'h0000, verify_target});
    wr(IDX_0, 16'h0200);
    {param_wr, verify_error, data_read, prog_read} = 4'b0111;
    #1 chk("data read invalid", 16'h0001, {15'h0000, data_read_invalid});
    chk("prog read invalid", 16'h0001, {15'h0000, prog_read_invalid});
    @(negedge ref_clk);
    {verify_error, data_read, prog_read} = 3'b000;
    chk("fault flags", 16'h0003, {14'h0000, single_fault_detect_flag, double_fault_detect_flag});
    chk("word0", 16'h0100, command_parameter_words[0]);
    wait_done(16'h4210);
    chk("verify all cycles", 16'h4200 - 16'h0002, n[15:0]);
    chk("verify flags", 16'h0002, {14'h0000, verify_error_flag_1, verify_error_flag_0});
    cmd(CMD_VERIFY_BLOCK, BLK_DATA, 16'h0000, 16'h0000, IDX_0);
    {verify_error, verify_uncorrectable} = 2'b11;
    @(negedge ref_clk);
    {verify_error, verify_uncorrectable} = 2'b00;
    wait_done(16'h0210);
    chk("verify block cycles", 16'h0200 - 16'h0001, n[15:0]);
    chk("verify flags", 16'h0003, {14'h0000, verify_error_flag_1, verify_error_flag_0});
    cmd(CMD_VERIFY_SECTION, BLK_PROG_HI, 16'hFFF0, 16'h0002, IDX_2);
    wait_done(16);
    chk("section cycles", 16'h0002, n[15:0]);
    $display("test verify done");
    cmd(CMD_READ_ONCE, 2'h0, 16'h0007, 16'h0000, IDX_1);
    prog_read = 1'b1;
    #1 chk("prog read invalid", 16'h0001, {15'h0000, prog_read_invalid});
    @(negedge ref_clk);
    prog_read = 1'b0;
    wait_done(16);
    chk("read once cycles", 16'h0003, n[15:0]);
    for (int k = 0; k < 4; k++) chk("once word", 16'hA51C + 16'(k), command_parameter_words[2 + k]);
    $display("test read once done");
    data_busy = 1'b1;
    cc(FVS_OP_PROG, 8'h00, 1'b1);
    cc(FVS_OP_SECTOR, 8'h00, 1'b1);
    cc(FVS_OP_MARGIN, 8'h00, 1'b1);
    cc(FVS_OP_MASS, 8'h00, 1'b0);
    cc(FVS_OP_SECTOR, CMD_ERASE_SECTOR, 1'b1);
    cc(FVS_OP_SECTOR, CMD_PROGRAM, 1'b0);
    cc(FVS_OP_PROG, CMD_PROGRAM, 1'b0);
    cc(FVS_OP_MARGIN, CMD_ERASE_SECTOR, 1'b0);
    cc(FVS_OP_MASS, CMD_ERASE_ALL, 1'b1);
    cc(FVS_OP_MASS, CMD_ERASE_BLOCK, 1'b1);
    {prog_op_req, data_busy} = 2'b00;
    cmd(CMD_USER_MARGIN, 2'h0, 16'h0001, 16'h0000, IDX_1);
    {data_busy, prog_read, data_read} = 3'b111;
    #1 chk("margin read", 16'h0001, {15'h0000, margin_read});
    cc(FVS_OP_PROG, 8'h00, 1'b0);
    cc(FVS_OP_MARGIN, 8'h00, 1'b1);
    {prog_op_req, data_busy, prog_read, data_read} = 4'b0000;
    $display("test concurrency done");
    stop_test();
  end
endmodule

bind fvs_sequencer fvs_sequencer_props u_props (.ref_clk, .sys_rst, .param_wr, .launch, .parameter_word_index,
  .command_parameter_words, .data_op, .data_busy, .prog_op_req, .prog_op_cmd, .prog_op_grant, .prog_read,
  .data_read, .prog_read_invalid, .data_read_invalid, .command_complete_flag, .access_error_flag,
  .protection_violation_flag, .single_fault_detect_flag, .double_fault_detect_flag);

// ### inc/fvs_pkg.sv
// package: constants, commands and states of the flash verify/read sequencer
package fvs_pkg;
  localparam logic [7:0] CMD_VERIFY_ALL     = 8'h01;
  localparam logic [7:0] CMD_VERIFY_BLOCK   = 8'h02;
  localparam logic [7:0] CMD_VERIFY_SECTION = 8'h03;
  localparam logic [7:0] CMD_READ_ONCE      = 8'h04;
  localparam logic [7:0] CMD_PROGRAM        = 8'h06;
  localparam logic [7:0] CMD_PROGRAM_ONCE   = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL      = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLOCK    = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECTOR   = 8'h0A;
  localparam logic [7:0] CMD_UNSECURE       = 8'h0B;
  localparam logic [7:0] CMD_VERIFY_KEY     = 8'h0C;
  localparam logic [7:0] CMD_USER_MARGIN    = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARGIN   = 8'h0E;
  localparam logic [7:0] CMD_DATA_SECTION   = 8'h10;
  localparam logic [7:0] CMD_DATA_PROGRAM   = 8'h11;
  localparam logic [7:0] CMD_DATA_SECTOR    = 8'h12;

  localparam logic [2:0] IDX_0 = 3'h0;
  localparam logic [2:0] IDX_1 = 3'h1;
  localparam logic [2:0] IDX_2 = 3'h2;
  localparam int         NUM_WORDS = 6;

  // global block codes in address bits [17:16]
  localparam logic [1:0] BLK_DATA      = 2'h0;
  localparam logic [1:0] BLK_PROG_LO   = 2'h2;
  localparam logic [1:0] BLK_PROG_HI   = 2'h3;
  localparam logic [2:0] PHRASE_ALIGN  = 3'h0;
  localparam logic [15:0] ONCE_MAX_IDX = 16'h0007;
  localparam int         ONCE_PHRASES  = 8;
  localparam int         ONCE_WORDS    = 32;
  // a section may not cross a 128 kbyte boundary: phrase count limit in bytes
  localparam int         BOUNDARY_KB   = 128;
  localparam logic [17:0] BOUNDARY_BYTES = 18'(BOUNDARY_KB * 1024);
  localparam logic [4:0]  PHRASE_BYTES = 5'h08;

  // cycles of verify per phrase; whole-array counts modelled as phrase counts
  localparam logic [15:0] PROG_PHRASES = 16'h4000;
  localparam logic [15:0] DATA_PHRASES = 16'h0200;
  localparam logic [15:0] ONCE_CYCLES  = 16'h0004;

  localparam logic [1:0] MARGIN_NORMAL = 2'h0;

  // concurrency classes of a data array operation
  typedef enum logic [4:0] {
    FVS_OP_IDLE   = 5'b00001,
    FVS_OP_MARGIN = 5'b00010,
    FVS_OP_PROG   = 5'b00100,
    FVS_OP_SECTOR = 5'b01000,
    FVS_OP_MASS   = 5'b10000
  } fvs_op_t;

  typedef enum logic [2:0] {
    FVS_ST_IDLE   = 3'b001,
    FVS_ST_VERIFY = 3'b010,
    FVS_ST_ONCE   = 3'b100
  } fvs_state_t;
endpackage
